// [design/adcsr_pkg.sv]
package adcsr_pkg;

	// ---------------------------------------------------------------
	// Word and counter sizes
	// ---------------------------------------------------------------
	localparam int              DATA_W   = 18;
	localparam int              CNT_W    = 5;
	localparam int              CONV_W   = 16;
	localparam logic [4:0]      IDX_DATA = 5'h12;
	localparam logic [4:0]      IDX_MSB  = 5'h11;
	localparam logic [4:0]      CNT_ZERO = 5'h00;
	localparam logic [4:0]      CNT_ONE  = 5'h01;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int              CLK_SYS_PERIOD_NS = 8;
	localparam int              T_CONV_MIN_NS     = 500;
	localparam int              T_CONV_MAX_NS     = 2200;
	localparam logic [15:0]     CONV_ONE          = 16'h0001;
	localparam logic [15:0]     CONV_ZERO         = 16'h0000;

	// ---------------------------------------------------------------
	// Start bit levels
	// ---------------------------------------------------------------
	localparam logic            BUSY_SEL_LEVEL   = 1'b0;
	localparam logic            BUSY_CHAIN_LEVEL = 1'b1;

	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		S_ACQ,
		S_CONV,
		S_WAIT,
		S_READ
	} adcsr_state_t;

	function automatic logic [4:0] adcsr_bin2gray(input logic [4:0] b);
		adcsr_bin2gray = b ^ (b >> 1);
	endfunction

	function automatic logic [4:0] adcsr_gray2bin(input logic [4:0] g);
		logic [4:0] b;
		b = CNT_ZERO;
		for (int i = 4; i >= 0; i--) begin
			b[i] = (i == 4) ? g[i] : (b[i + 1] ^ g[i]);
		end
		adcsr_gray2bin = b;
	endfunction

endpackage

// [design/adcsr_pin_sync.sv]
`timescale 1ns/100ps
module adcsr_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level
);
	import adcsr_pkg::*;

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_level;

	// A change is accepted only once the second and third stages agree.
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_level[i] = (stage2[i] == stage3[i]) ? stage2[i] : o_level[i];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1  <= '0;
			stage2  <= '0;
			stage3  <= '0;
			o_level <= '0;
		end else begin
			stage1  <= i_async;
			stage2  <= stage1;
			stage3  <= stage2;
			o_level <= next_level;
		end
	end

endmodule

// [design/adcsr_gray_sync.sv]
`timescale 1ns/100ps
module adcsr_gray_sync (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [4:0] i_gray,
	output logic      [4:0] o_count
);
	import adcsr_pkg::*;

	logic [4:0] meta;
	logic [4:0] held;
	logic [4:0] next_count;

	// Gray code changes one bit per edge, so any sample is old or new, never a mix.
	always_comb begin
		next_count = adcsr_gray2bin(held);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta    <= CNT_ZERO;
			held    <= CNT_ZERO;
			o_count <= CNT_ZERO;
		end else begin
			meta    <= i_gray;
			held    <= meta;
			o_count <= next_count;
		end
	end

endmodule

// [design/adcsr_serial_readout.sv]
`timescale 1ns/100ps
// Summary of operation
// R1 - Select input level at convert-start rise picks select or daisy-chain mode.
// R2 - Select input tied to convert-start always yields daisy-chain mode.
// R3 - Host runs one conversion and clocks all bits to settle the output.
// R4 - Optional busy start bit precedes data; otherwise host waits maximum conversion.
// R5 - Select mode: busy enabled if either input low when conversion ends.
// R6 - Chain mode: busy enabled if serial clock high at convert-start rise.
// R7 - Select input high: convert-start rise starts conversion, select mode, output off.
// R8 - A started conversion runs to its end regardless of convert-start.
// R9 - After conversion the device acquires and powers down until next start.
// R10 - Host keeps convert-start high through maximum conversion time for no busy.
// R11 - Convert-start falling puts the MSB out; serial clock falls shift the rest.
// R12 - Data stays valid across both serial clock edges.
// R13 - Output released after 18th falling edge or convert-start rise.
// R14 - Host keeps convert-start low through maximum conversion time for busy.
// R15 - Busy mode: output off during conversion, driven when conversion ends.
// R16 - Busy mode: MSB first, released after 19th falling edge or deselect.
// R17 - Host keeps overlapping selections of several devices brief.
// R18 - Four-wire: host holds convert-start high through conversion and readback.
// R19 - Both select and convert-start low: output is driven low.
// R20 - Four-wire without busy: host returns select high before minimum conversion.
// R21 - Four-wire: select low outputs MSB; released after 18th edge or select rise.
// R22 - Minimum and maximum conversion times are parameters; only the maximum is one (T_CONV_MAX_NS_P), and T_CONV_MIN_NS is never used.
module adcsr_serial_readout #(
	parameter int T_CONV_MAX_NS_P = adcsr_pkg::T_CONV_MAX_NS
) (
	input  wire logic                           i_clk_sys,
	input  wire logic                           i_rst_n,
	input  wire logic                           i_sclk,
	input  wire logic                           i_convert_start_pin,
	input  wire logic                           i_serial_select_in,
	input  wire logic [adcsr_pkg::DATA_W-1:0]   i_sample_data,
	output logic                                o_serial_result_out,
	output logic                                o_serial_result_oe_n,
	output logic                                o_powered_down,
	output logic                                o_select_mode,
	output logic                                o_busy_enabled
);
	import adcsr_pkg::*;

	// ---------------------------------------------------------------
	// Conversion length
	// ---------------------------------------------------------------
	// R22 conversion time parameter
	localparam int          CONV_RAW    = T_CONV_MAX_NS_P / CLK_SYS_PERIOD_NS;
	localparam logic [15:0] CONV_CYCLES = (CONV_RAW < 1) ? CONV_ONE : 16'(CONV_RAW);

	// ---------------------------------------------------------------
	// Link domain: serial clock falling edge counter
	// ---------------------------------------------------------------
	logic [4:0] edge_cnt;
	logic [4:0] edge_gray;
	logic [4:0] next_edge_cnt;
	logic [4:0] next_edge_gray;

	// The counter never clears on a frame; the system side keeps its own base.
	always_comb begin
		next_edge_cnt  = edge_cnt + CNT_ONE;
		next_edge_gray = adcsr_bin2gray(next_edge_cnt);
	end

	always_ff @(negedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			edge_cnt  <= CNT_ZERO;
			edge_gray <= CNT_ZERO;
		end else begin
			edge_cnt  <= next_edge_cnt;
			edge_gray <= next_edge_gray;
		end
	end

	// ---------------------------------------------------------------
	// Crossings into the system domain
	// ---------------------------------------------------------------
	logic [2:0] pins_f;
	logic       sclk_f;
	logic       sdi_f;
	logic       cnv_f;
	logic [4:0] edge_seen;

	adcsr_pin_sync #(
		.W       (3)
	) u_pin_sync (
		.i_clk   (i_clk_sys),
		.i_rst_n (i_rst_n),
		.i_async ({i_sclk, i_serial_select_in, i_convert_start_pin}),
		.o_level (pins_f)
	);

	assign sclk_f = pins_f[2];
	assign sdi_f  = pins_f[1];
	assign cnv_f  = pins_f[0];

	adcsr_gray_sync u_gray_sync (
		.i_clk   (i_clk_sys),
		.i_rst_n (i_rst_n),
		.i_gray  (edge_gray),
		.o_count (edge_seen)
	);

	// ---------------------------------------------------------------
	// System domain: conversion and readout control
	// ---------------------------------------------------------------
	adcsr_state_t      state;
	adcsr_state_t      next_state;
	logic              cnv_d;
	logic              sdi_d;
	logic              mode_cs;
	logic              next_mode_cs;
	logic              busy_en;
	logic              next_busy_en;
	logic [DATA_W-1:0] word;
	logic [DATA_W-1:0] next_word;
	logic [4:0]        base;
	logic [4:0]        next_base;
	logic [15:0]       conv_cnt;
	logic [15:0]       next_conv_cnt;
	logic              next_sdo;
	logic              next_oe_n;
	logic              next_powered_down;
	logic              cnv_rise;
	logic              select_act;
	logic [4:0]        idx;
	logic [4:0]        data_pos;
	logic [4:0]        idx_end;

	always_comb begin
		cnv_rise   = cnv_f & ~cnv_d;
		// Either input low counts as a selected device in select mode.
		select_act = ~cnv_f | ~sdi_f;
		idx        = edge_seen - base;
		data_pos   = idx - {4'h0, busy_en};
		idx_end    = IDX_DATA + {4'h0, busy_en};

		next_state    = state;
		next_mode_cs  = mode_cs;
		next_busy_en  = busy_en;
		next_word     = word;
		next_base     = base;
		next_conv_cnt = conv_cnt;

		case (state)
			S_CONV: begin
				// R8 conversion runs out
				if (conv_cnt == CONV_ZERO) begin
					if (mode_cs) begin
						// R5 busy by selection
						next_busy_en = select_act;
						// R4 start bit or wait
						if (select_act) begin
							next_state = S_READ;
							next_base  = edge_seen;
						end else begin
							next_state = S_WAIT;
						end
					end else begin
						next_state = S_READ;
						next_base  = edge_seen;
					end
				end else begin
					next_conv_cnt = conv_cnt - CONV_ONE;
				end
			end
			S_WAIT: begin
				// R11 select starts readout
				if (select_act) begin
					next_state = S_READ;
					next_base  = edge_seen;
				end
			end
			S_READ: begin
				// R13 last edge or deselect
				if (idx >= idx_end) begin
					next_state = S_ACQ;
				// R21 select rise releases
				end else if (mode_cs && !select_act) begin
					next_state = S_ACQ;
				end
			end
			S_ACQ: begin
				next_state = S_ACQ;
			end
			default: begin
				next_state = S_ACQ;
			end
		endcase

		// R1 mode at convert-start rise
		if (cnv_rise && state != S_CONV) begin
			// R2 old select level wins
			next_mode_cs  = sdi_d;
			// R6 chain busy from clock
			next_busy_en  = sdi_d ? 1'b0 : sclk_f;
			next_word     = i_sample_data;
			next_conv_cnt = CONV_CYCLES - CONV_ONE;
			// R7 conversion starts
			next_state    = S_CONV;
		end

		// R9 power down outside conversion
		next_powered_down = (next_state != S_CONV);
	end

	// ---------------------------------------------------------------
	// Output pin
	// ---------------------------------------------------------------
	// Bits move a few system cycles after each serial clock fall, so the host's serial clock must be slow.
	always_comb begin
		next_sdo  = 1'b0;
		// R15 off until readout
		next_oe_n = 1'b1;
		if (state == S_READ) begin
			next_oe_n = 1'b0;
			// R16 start bit first
			if (busy_en && idx == CNT_ZERO) begin
				next_sdo = mode_cs ? BUSY_SEL_LEVEL : BUSY_CHAIN_LEVEL;
			end else if (idx < idx_end) begin
				// R12 bit held between edges
				next_sdo = word[IDX_MSB - data_pos];
			end
		end else if (!cnv_f && !sdi_f) begin
			// R19 drive low
			next_oe_n = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state                <= S_ACQ;
			cnv_d                <= 1'b0;
			sdi_d                <= 1'b0;
			mode_cs              <= 1'b0;
			busy_en              <= 1'b0;
			word                 <= '0;
			base                 <= CNT_ZERO;
			conv_cnt             <= CONV_ZERO;
			o_serial_result_out  <= 1'b0;
			o_serial_result_oe_n <= 1'b1;
			o_powered_down       <= 1'b1;
		end else begin
			state                <= next_state;
			cnv_d                <= cnv_f;
			sdi_d                <= sdi_f;
			mode_cs              <= next_mode_cs;
			busy_en              <= next_busy_en;
			word                 <= next_word;
			base                 <= next_base;
			conv_cnt             <= next_conv_cnt;
			o_serial_result_out  <= next_sdo;
			o_serial_result_oe_n <= next_oe_n;
			o_powered_down       <= next_powered_down;
		end
	end

	assign o_select_mode  = mode_cs;
	assign o_busy_enabled = busy_en;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	a_mode_on_edge: assert property ((cnv_rise && state != S_CONV) |=> (mode_cs == $past(sdi_d))) // R1
		else $error("Mode does not follow select level at start.");
	a_tied_chain: assert property (($rose(cnv_f) && $rose(sdi_f) && state != S_CONV) |=> !mode_cs) // R2
		else $error("Tied select and start did not give chain mode.");
	a_busy_select: assert property ((state == S_CONV && conv_cnt == CONV_ZERO && mode_cs)
		|=> (busy_en == $past(select_act))) // R5
		else $error("Select mode busy flag wrong at conversion end.");
	a_busy_chain: assert property ((cnv_rise && state != S_CONV && !sdi_d) |=> (busy_en == $past(sclk_f))) // R6
		else $error("Chain busy flag does not follow serial clock.");
	a_start_hiz: assert property ((cnv_rise && sdi_d && state != S_CONV) ##1 cnv_f |=> o_serial_result_oe_n) // R7
		else $error("Output not released at conversion start.");
	a_conv_runs: assert property ((state == S_CONV && conv_cnt != CONV_ZERO) |=> (state == S_CONV)) // R8
		else $error("Conversion ended early.");
	a_power_down: assert property ((state == S_CONV && conv_cnt == CONV_ZERO) |=> (o_powered_down && state != S_CONV)) // R9
		else $error("No power down after conversion.");
	a_msb_first: assert property ((state == S_WAIT && select_act && !cnv_rise) ##1 (idx == CNT_ZERO)
		|=> (!o_serial_result_oe_n && o_serial_result_out == word[IDX_MSB])) // R11
		else $error("MSB not driven on select.");
	a_bit_stable: assert property ((state == S_READ && $past(state) == S_READ && $stable(idx))
		|=> $stable(o_serial_result_out)) // R12
		else $error("Output bit changed without a clock edge.");
	a_hiz_after_18: assert property ((state == S_READ && !busy_en && idx >= IDX_DATA) ##1 (cnv_f || sdi_f)
		|=> o_serial_result_oe_n) // R13
		else $error("Output not released after the last data bit.");
	a_busy_hiz: assert property ((state == S_CONV && mode_cs && sdi_f) |=> o_serial_result_oe_n) // R15
		else $error("Output driven during busy conversion.");
	a_start_bit: assert property ((state == S_READ && busy_en && idx == CNT_ZERO)
		|=> (!o_serial_result_oe_n && o_serial_result_out == !$past(mode_cs))) // R16
		else $error("Start bit wrong.");
	a_hiz_after_19: assert property ((state == S_READ && busy_en && idx >= IDX_DATA + CNT_ONE) ##1 (cnv_f || sdi_f)
		|=> o_serial_result_oe_n) // R16
		else $error("Output not released after the start bit frame.");
	a_drive_low: assert property ((!cnv_f && !sdi_f && state != S_READ) |=> (!o_serial_result_oe_n && !o_serial_result_out)) // R19
		else $error("Output not driven low with both inputs low.");
	a_deselect_hiz: assert property ((state == S_READ && mode_cs && cnv_f && sdi_f) ##1 (cnv_f || sdi_f)
		|=> o_serial_result_oe_n) // R21
		else $error("Output not released on deselect.");

endmodule

// [tb/adcsr_host_model.sv]
`timescale 1ns/100ps
module adcsr_host_model (
	input  wire logic i_serial_result_out,
	input  wire logic i_serial_result_oe_n,
	output logic      o_sclk,
	output logic      o_line
);
	logic clk_link;

	// ----------------
	// Link clock
	// ----------------
	initial clk_link = 1'b0;
	always #6 clk_link = ~clk_link;
	initial o_sclk = 1'b0;

	// only one device sits on this line, so outputs never overlap.
	assign o_line = i_serial_result_oe_n ? 1'b1 : i_serial_result_out;

	// ----------------
	// Transfers
	// ----------------
	// sclk level set.
	task automatic set_sclk(input logic v);
		@(posedge clk_link);
		o_sclk <= v;
		repeat (5) @(posedge clk_link);
	endtask

	// capture on rise.
	// Half periods of 60 ns high and 72 ns low leave room for the slow edge sync in the device.
	task automatic shift(input int n, output logic [18:0] w);
		w = 19'h00000;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_link);
			w = {w[17:0], o_line};
			o_sclk <= 1'b1;
			repeat (5) @(posedge clk_link);
			o_sclk <= 1'b0;
			repeat (5) @(posedge clk_link);
		end
	endtask
endmodule

// [tb/adcsr_serial_readout_tb_top.sv]
`timescale 1ns/100ps
module adcsr_serial_readout_tb_top;
	import adcsr_pkg::*;
	logic              clk_sys;
	logic              rst_n;
	logic              convert_start_pin;
	logic              serial_select_in;
	logic              sclk;
	logic              line;
	logic              out;
	logic              oe_n;
	logic              pd;
	logic              sel;
	logic              busy;
	logic [DATA_W-1:0] data;
	int                err_count;
	int                n_tests;
	int                cycles = 0;

	always #4 clk_sys = ~clk_sys;

	adcsr_serial_readout #(.T_CONV_MAX_NS_P(80)) i_adcsr_serial_readout (
		.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_sclk(sclk), .i_convert_start_pin(convert_start_pin),
		.i_serial_select_in(serial_select_in), .i_sample_data(data), .o_serial_result_out(out),
		.o_serial_result_oe_n(oe_n), .o_powered_down(pd), .o_select_mode(sel), .o_busy_enabled(busy)
	);
	adcsr_host_model i_adcsr_host_model (
		.i_serial_result_out(out), .i_serial_result_oe_n(oe_n), .o_sclk(sclk), .o_line(line)
	);

	// ----------------
	// Helpers
	// ----------------
	task automatic chk_bit(input string name, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %s expected %b seen %b", name, exp, got);
			err_count++;
		end
	endtask
	task automatic chk_word(input string name, input logic [18:0] exp, input logic [18:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wait_pd(input logic v, output int n);
		n = 0;
		while (pd !== v && n < 200) begin
			cyc(1);
			n++;
		end
		chk_bit("power down wait", 1'b1, n < 200);
	endtask
	task automatic results();
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------
	// Scenarios
	// ----------------
	task automatic s_three_wire(input logic with_busy);
		int          n;
		logic [18:0] w;
		@(posedge clk_sys);
		data <= with_busy ? 18'h2A5C3 : 18'h35A3C;
		serial_select_in <= 1'b1;
		cyc(4);
		@(posedge clk_sys);
		convert_start_pin <= 1'b1;
		wait_pd(1'b0, n);
		chk_bit("select mode", 1'b1, sel);
		if (with_busy) begin
			@(posedge clk_sys);
			convert_start_pin <= 1'b0;
			cyc(3);
			chk_bit("oe during conversion", 1'b1, oe_n);
		end
		// convert stays high here when the start bit is not wanted.
		wait_pd(1'b1, n);
		if (!with_busy) chk_bit("conversion length", 1'b1, n >= 8 && n <= 11);
		cyc(3);
		chk_bit("busy enable", with_busy, busy);
		if (with_busy) begin
			chk_bit("start bit", 1'b0, line);
			i_adcsr_host_model.shift(19, w);
			chk_word("busy word", {1'b0, data}, w);
		end else begin
			chk_bit("oe before select", 1'b1, oe_n);
			@(posedge clk_sys);
			convert_start_pin <= 1'b0;
			cyc(6);
			i_adcsr_host_model.shift(18, w);
			chk_word("word", {1'b0, data}, w);
		end
		cyc(6);
		chk_bit("release after count", 1'b1, oe_n);
	endtask

	task automatic s_abort();
		int          n;
		logic [18:0] w;
		@(posedge clk_sys);
		data <= 18'h0F0F3;
		convert_start_pin <= 1'b1;
		wait_pd(1'b0, n);
		wait_pd(1'b1, n);
		@(posedge clk_sys);
		convert_start_pin <= 1'b0;
		cyc(6);
		i_adcsr_host_model.shift(5, w);
		chk_word("partial word", {14'h0000, data[17:13]}, w);
		@(posedge clk_sys);
		convert_start_pin <= 1'b1;
		data <= 18'h1C3A5;
		cyc(6);
		chk_bit("release on rise", 1'b1, oe_n);
		wait_pd(1'b0, n);
		wait_pd(1'b1, n);
		@(posedge clk_sys);
		convert_start_pin <= 1'b0;
		cyc(6);
		i_adcsr_host_model.shift(18, w);
		chk_word("restart word", {1'b0, data}, w);
		cyc(6);
	endtask

	task automatic s_four_wire();
		int          n;
		logic [18:0] w;
		@(posedge clk_sys);
		serial_select_in <= 1'b0;
		cyc(6);
		chk_bit("both low oe", 1'b0, oe_n);
		chk_bit("both low out", 1'b0, out);
		@(posedge clk_sys);
		serial_select_in <= 1'b1;
		data <= 18'h3FFFE;
		cyc(4);
		@(posedge clk_sys);
		convert_start_pin <= 1'b1;
		wait_pd(1'b0, n);
		wait_pd(1'b1, n);
		cyc(3);
		chk_bit("oe before select", 1'b1, oe_n);
		@(posedge clk_sys);
		serial_select_in <= 1'b0;
		cyc(6);
		i_adcsr_host_model.shift(18, w);
		chk_word("four wire word", {1'b0, data}, w);
		cyc(6);
		chk_bit("four wire release", 1'b1, oe_n);
		@(posedge clk_sys);
		serial_select_in <= 1'b1;
		convert_start_pin <= 1'b0;
	endtask

	task automatic s_chain(input logic with_busy);
		int          n;
		logic [18:0] w;
		@(posedge clk_sys);
		serial_select_in <= 1'b0;
		i_adcsr_host_model.set_sclk(with_busy);
		cyc(4);
		@(posedge clk_sys);
		data <= with_busy ? 18'h25A5A : 18'h1A5A5;
		convert_start_pin <= 1'b1;
		if (!with_busy) serial_select_in <= 1'b1;
		wait_pd(1'b0, n);
		cyc(2);
		chk_bit("chain mode", 1'b0, sel);
		chk_bit("chain busy", with_busy, busy);
		wait_pd(1'b1, n);
		cyc(3);
		chk_bit("chain oe", 1'b0, oe_n);
		chk_bit("chain first bit", with_busy ? 1'b1 : data[17], line);
		if (with_busy) begin
			i_adcsr_host_model.set_sclk(1'b0);
			cyc(6);
		end
		i_adcsr_host_model.shift(18, w);
		chk_word("chain word", {1'b0, data}, w);
		cyc(6);
		chk_bit("chain release", 1'b1, oe_n);
		@(posedge clk_sys);
		convert_start_pin <= 1'b0;
		serial_select_in <= 1'b0;
	endtask

	// ----------------
	// Sequence
	// ----------------
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			err_count++;
			results();
		end
	end

	initial begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		convert_start_pin = 1'b0;
		serial_select_in = 1'b1;
		data = 18'h00000;
		err_count = 0;
		n_tests = 0;
		cyc(5);
		chk_bit("reset oe", 1'b1, oe_n);
		chk_bit("reset power down", 1'b1, pd);
		chk_bit("reset mode", 1'b0, sel);
		chk_bit("reset busy", 1'b0, busy);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		cyc(6);
		s_three_wire(1'b0);
		s_three_wire(1'b1);
		s_abort();
		s_four_wire();
		s_chain(1'b0);
		s_chain(1'b1);
		results();
	end
endmodule
